// File: rtl/tccc_pkg.sv
package tccc_pkg;
    localparam logic [11:0] ADDR_SELECT = 12'h000;
    localparam logic [11:0] ADDR_FORCE = 12'h004;
    localparam logic [11:0] ADDR_MASK = 12'h008;
    localparam logic [11:0] ADDR_DATA = 12'h00c;
    localparam logic [11:0] ADDR_COUNTER = 12'h010;
    localparam logic [11:0] ADDR_CONTROL = 12'h018;
    // own registers
    localparam logic [11:0] ADDR_ACTION = 12'h020;
    localparam logic [11:0] ADDR_FLAGS = 12'h024;
    localparam logic [11:0] ADDR_CHVAL4 = 12'h040;
    localparam logic [11:0] ADDR_ACC_CNT = 12'h050;
    localparam int CTL_RUN = 7;
    localparam int CTL_WAIT = 6;
    localparam int CTL_FRZ = 5;
    localparam int CTL_FAST = 4;
    localparam int FLG_OVF = 4;
    localparam int FLG_ACC_OVF = 5;
    localparam int FLG_ACC_IN = 6;
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam int ACC_DIV = 64;
    localparam logic [5:0] ACC_DIV_LAST = 6'(ACC_DIV - 1);
    localparam logic [1:0] ACT_OFF = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_LOW = 2'h2;
    localparam logic [1:0] ACT_HIGH = 2'h3;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } tccc_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tccc_apb_rsp_t;
endpackage

// File: rtl/tccc_prescale.sv
`timescale 1ns/1ps
`default_nettype none
module tccc_prescale (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic run,
    input wire logic tick_in,
    // divided tick
    output logic tick_out
);
    import tccc_pkg::*;

    typedef struct packed {
        logic [5:0] cnt;
        logic tick;
    } tccc_pre_state_t;

    tccc_pre_state_t st;
    tccc_pre_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (!run) begin
            next_st.cnt = 6'h00; // no accumulator clock while stopped
        end else if (tick_in) begin
            if (st.cnt == ACC_DIV_LAST) begin
                next_st.cnt = 6'h00;
                next_st.tick = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick_out = st.tick;

    acc_tick_gated_a: assert property (@(posedge clk) disable iff (!rst_n)
        tick_out |-> $past(run))
        else $error("accumulator tick while timer stopped");
endmodule // tccc_prescale
`default_nettype wire

// File: rtl/tccc_top.sv
`timescale 1ns/1ps
`default_nettype none
module tccc_top (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_B,
    // apb
    input wire tccc_pkg::tccc_apb_req_t APB_REQ,
    output tccc_pkg::tccc_apb_rsp_t APB_RSP,
    // chip mode
    input wire logic SPECIAL_MODE,
    input wire logic WAIT_MODE,
    input wire logic FREEZE_MODE,
    // channel pins 7..4
    input wire logic [3:0] CH_IN,
    output logic [3:0] CH_OUT,
    output logic [3:0] CH_OE,
    // accumulator
    output logic ACC_CLK_TICK
);
    import tccc_pkg::*;

    typedef struct packed {
        logic [3:0] capture_or_compare_sel;
        logic [3:0] master_compare_mask;
        logic [3:0] master_compare_data;
        logic [7:0] action;
        logic [3:0] system_control_one;
        logic [15:0] main_counter;
        logic [63:0] chval;
        logic [3:0] channel_event_flag;
        logic counter_overflow_flag;
        logic [1:0] accumulator_flags;
        logic [15:0] acc_cnt;
        logic [3:0] port_data;
        logic [3:0] pin_d1;
        logic [3:0] pin_d2;
        logic [3:0] pin_d3;
        logic [31:0] rdata;
        logic ready;
    } tccc_state_t;

    tccc_state_t st;
    tccc_state_t next_st;
    logic [1:0] rst_sync;
    logic rst_n;
    logic run;
    logic cnt_tick;
    logic acc_tick;

    function automatic logic apply_action(input logic [1:0] act, input logic cur);
        case (act)
            ACT_TOGGLE: apply_action = ~cur;
            ACT_LOW: apply_action = 1'b0;
            ACT_HIGH: apply_action = 1'b1;
            default: apply_action = cur;
        endcase
    endfunction

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // timer runs unless disabled, wait-stopped
    assign run = st.system_control_one[CTL_RUN - 4]
        && !(WAIT_MODE && st.system_control_one[CTL_WAIT - 4]);
    // freeze stops only the counter
    assign cnt_tick = run && !(FREEZE_MODE && st.system_control_one[CTL_FRZ - 4]);

    tccc_prescale u_pre (
        .clk(CLK_SYS),
        .rst_n(rst_n),
        .run(run),
        .tick_in(1'b1),
        .tick_out(acc_tick)
    );

    always_comb begin
        logic acc;
        logic wr;
        logic rd;
        logic fast;
        logic [3:0] force_now;
        logic [3:0] match;
        logic [3:0] cap_edge;
        logic [3:0] ch_set;
        logic [11:0] a;
        acc = APB_REQ.psel && APB_REQ.penable && !st.ready;
        wr = acc && APB_REQ.pwrite;
        rd = acc && !APB_REQ.pwrite;
        a = APB_REQ.paddr;
        fast = st.system_control_one[CTL_FAST - 4];
        force_now = 4'h0;
        match = 4'h0;
        ch_set = 4'h0;
        cap_edge = st.pin_d2 ^ st.pin_d3;
        next_st = st;
        next_st.ready = acc;
        next_st.pin_d1 = CH_IN;
        next_st.pin_d2 = st.pin_d1;
        next_st.pin_d3 = st.pin_d2;
        if (cnt_tick) begin
            next_st.main_counter = st.main_counter + 16'h0001;
            if (st.main_counter == 16'hffff) begin
                next_st.counter_overflow_flag = 1'b1;
            end
        end
        for (int i = 0; i < 4; i++) begin
            if (st.capture_or_compare_sel[i]) begin
                match[i] = cnt_tick && (st.chval[i*16 +: 16] == st.main_counter);
            end else if (cap_edge[i] && run) begin
                next_st.chval[i*16 +: 16] = st.main_counter;
                next_st.channel_event_flag[i] = 1'b1;
                ch_set[i] = 1'b1;
            end
        end
        if (wr && a == ADDR_FORCE) begin
            force_now = APB_REQ.pwdata[7:4] & st.capture_or_compare_sel;
        end
        // per-channel action, channel 7 override applied after
        for (int i = 0; i < 4; i++) begin
            if (force_now[i] || match[i]) begin
                next_st.port_data[i] = apply_action(st.action[i*2 +: 2],
                    st.port_data[i]);
            end
            if (match[i] && !force_now[i]) begin
                next_st.channel_event_flag[i] = 1'b1;
                ch_set[i] = 1'b1;
            end
        end
        if (match[3] || force_now[3]) begin
            for (int i = 0; i < 4; i++) begin
                if (st.master_compare_mask[i]) begin
                    next_st.port_data[i] = st.master_compare_data[i];
                end
            end
        end
        next_st.rdata = 32'h0;
        if (rd) begin
            if (a == ADDR_SELECT) begin
                next_st.rdata = {24'h0, st.capture_or_compare_sel, 4'h0};
            end else if (a == ADDR_FORCE) begin
                next_st.rdata = 32'h0;
            end else if (a == ADDR_MASK) begin
                next_st.rdata = {24'h0, st.master_compare_mask, 4'h0};
            end else if (a == ADDR_DATA) begin
                next_st.rdata = {24'h0, st.master_compare_data, 4'h0};
            end else if (a == ADDR_COUNTER) begin
                next_st.rdata = {16'h0, st.main_counter};
            end else if (a == ADDR_CONTROL) begin
                next_st.rdata = {24'h0, st.system_control_one, 4'h0};
            end else if (a == ADDR_ACTION) begin
                next_st.rdata = {24'h0, st.action};
            end else if (a == ADDR_FLAGS) begin
                next_st.rdata = {25'h0, st.accumulator_flags,
                    st.counter_overflow_flag, st.channel_event_flag};
            end else if (a == ADDR_ACC_CNT) begin
                next_st.rdata = {16'h0, st.acc_cnt};
            end else begin
                for (int i = 0; i < 4; i++) begin
                    if (a == ADDR_CHVAL4 + 12'(i * 4)) begin
                        next_st.rdata = {16'h0, st.chval[i*16 +: 16]};
                    end
                end
            end
        end
        if (wr) begin
            if (a == ADDR_SELECT) begin
                next_st.capture_or_compare_sel = APB_REQ.pwdata[7:4];
            end else if (a == ADDR_MASK) begin
                next_st.master_compare_mask = APB_REQ.pwdata[7:4];
            end else if (a == ADDR_DATA) begin
                next_st.master_compare_data = APB_REQ.pwdata[7:4];
            end else if (a == ADDR_COUNTER && SPECIAL_MODE) begin
                // counter has no prescaler; the accumulator prescaler is left alone
                next_st.main_counter = APB_REQ.pwdata[15:0];
            end else if (a == ADDR_CONTROL) begin
                next_st.system_control_one = APB_REQ.pwdata[7:4];
            end else if (a == ADDR_ACTION) begin
                next_st.action = APB_REQ.pwdata[7:0];
            end else if (a == ADDR_FLAGS) begin
                // write-one-to-clear: explicit path
                next_st.channel_event_flag = next_st.channel_event_flag
                    & ~(APB_REQ.pwdata[3:0] & ~ch_set);
                if (APB_REQ.pwdata[FLG_OVF] && !(cnt_tick && st.main_counter == 16'hffff)) begin
                    next_st.counter_overflow_flag = 1'b0;
                end
                next_st.accumulator_flags = st.accumulator_flags
                    & ~APB_REQ.pwdata[FLG_ACC_IN:FLG_ACC_OVF];
            end else if (a == ADDR_ACC_CNT) begin
                next_st.acc_cnt = APB_REQ.pwdata[15:0];
            end else begin
                for (int i = 0; i < 4; i++) begin
                    if (a == ADDR_CHVAL4 + 12'(i * 4)) begin
                        next_st.chval[i*16 +: 16] = APB_REQ.pwdata[15:0];
                    end
                end
            end
        end
        if (fast && acc) begin
            for (int i = 0; i < 4; i++) begin
                if (a == ADDR_CHVAL4 + 12'(i * 4)
                    && ((rd && !st.capture_or_compare_sel[i] && !(cap_edge[i] && run))
                    || (wr && st.capture_or_compare_sel[i] && !match[i]))) begin
                    next_st.channel_event_flag[i] = 1'b0;
                end
            end
            if (a == ADDR_COUNTER && !(cnt_tick && st.main_counter == 16'hffff)) begin
                next_st.counter_overflow_flag = 1'b0;
            end
            if (a == ADDR_ACC_CNT) begin
                next_st.accumulator_flags = 2'b00;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign APB_RSP.pready = st.ready;
    assign APB_RSP.pslverr = 1'b0;
    assign APB_RSP.prdata = st.rdata;
    assign CH_OUT = st.port_data;
    // pin driven on a compare channel when its action is nonzero or it is masked
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            CH_OE[i] = st.capture_or_compare_sel[i]
                && (st.master_compare_mask[i] || st.action[i*2 +: 2] != ACT_OFF);
        end
    end
    assign ACC_CLK_TICK = acc_tick;

    force_reads_zero_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        (APB_REQ.psel && APB_REQ.penable && !APB_REQ.pwrite && !st.ready
        && APB_REQ.paddr == ADDR_FORCE) |=> st.rdata == 32'h0)
        else $error("force register read nonzero");
    counter_up_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        (cnt_tick && !(APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite))
        |=> st.main_counter == $past(st.main_counter) + 16'h0001)
        else $error("counter failed to increment");
    counter_wprot_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        (!SPECIAL_MODE && !cnt_tick) |=> st.main_counter == $past(st.main_counter))
        else $error("counter changed outside special mode");
    timer_stop_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        (!st.system_control_one[CTL_RUN - 4] && !SPECIAL_MODE)
        |=> st.main_counter == $past(st.main_counter))
        else $error("counter ran while disabled");
    freeze_halt_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        (FREEZE_MODE && st.system_control_one[CTL_FRZ - 4]
        && !(APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite))
        |=> st.main_counter == $past(st.main_counter))
        else $error("counter ran in freeze");
    wait_halt_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        (WAIT_MODE && st.system_control_one[CTL_WAIT - 4]
        && !(APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite))
        |=> (st.main_counter == $past(st.main_counter) && !acc_tick))
        else $error("timer ran in wait");
    mask_oe_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        (|(st.capture_or_compare_sel & st.master_compare_mask))
        |-> (st.capture_or_compare_sel & st.master_compare_mask & ~CH_OE) == 4'h0)
        else $error("masked compare pin not driven");
    ovf_fast_clear_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        (st.system_control_one[CTL_FAST - 4] && APB_REQ.psel && APB_REQ.penable && !st.ready
        && APB_REQ.paddr == ADDR_COUNTER && !(cnt_tick && st.main_counter == 16'hffff))
        |=> !st.counter_overflow_flag)
        else $error("overflow flag kept after counter access");
    ovf_hold_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        (!st.system_control_one[CTL_FAST - 4] && st.counter_overflow_flag
        && !(APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite && APB_REQ.paddr == ADDR_FLAGS))
        |=> st.counter_overflow_flag)
        else $error("overflow flag lost without explicit clear");
    force_no_flag_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        (APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite && !st.ready
        && APB_REQ.paddr == ADDR_FORCE)
        |=> (st.channel_event_flag & ~$past(st.channel_event_flag)
        & $past(APB_REQ.pwdata[7:4]) & $past(st.capture_or_compare_sel)) == 4'h0)
        else $error("forced channel flag set");
    sel_reset_a: assert property (@(posedge CLK_SYS)
        $rose(rst_n) |-> st.capture_or_compare_sel == RST_NIBBLE)
        else $error("select not cleared at reset");
endmodule // tccc_top
`default_nettype wire

// File: testbench/tccc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tccc_pin_model (
    // design side of the pins
    input wire logic [3:0] ch_out,
    input wire logic [3:0] ch_oe,
    // level set by the outside world
    input wire logic [3:0] ext_level,
    // level seen back by the design
    output logic [3:0] ch_in
);
    // a driving channel owns its pin; an undriven pin follows the outside level
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            ch_in[i] = ch_oe[i] ? ch_out[i] : ext_level[i];
        end
    end
endmodule // tccc_pin_model
`default_nettype wire

// File: testbench/test_timer_capture_compare_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_timer_capture_compare_ctrl;
    import tccc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    tccc_apb_req_t apb_req = '0;
    tccc_apb_rsp_t apb_rsp;
    logic special_mode = 1'b0;
    logic wait_mode = 1'b0;
    logic freeze_mode = 1'b0;
    logic [3:0] ext_level = 4'h0;
    logic [3:0] ch_in, ch_out, ch_oe;
    logic acc_tick;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [15:0] ticks = 16'h0;
    logic [31:0] v;
    // control first, so the timer never meets a compare channel at count zero
    logic [11:0] rw_addr [4] = '{ADDR_CONTROL, ADDR_SELECT, ADDR_MASK, ADDR_DATA};

    always #10 clk_sys = ~clk_sys;

    tccc_top u_dut (.CLK_SYS(clk_sys), .RST_B(rst_b), .APB_REQ(apb_req), .APB_RSP(apb_rsp),
        .SPECIAL_MODE(special_mode), .WAIT_MODE(wait_mode), .FREEZE_MODE(freeze_mode),
        .CH_IN(ch_in), .CH_OUT(ch_out), .CH_OE(ch_oe), .ACC_CLK_TICK(acc_tick));

    tccc_pin_model u_pins (.ch_out(ch_out), .ch_oe(ch_oe), .ext_level(ext_level),
        .ch_in(ch_in));

    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check_word(input string name, input logic [31:0] exp,
                              input logic [31:0] got, input logic [31:0] msk);
        n_compared++;
        if ((got & msk) !== (exp & msk)) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp & msk, got & msk);
        end
    endtask

    task automatic check_pin(input string name, input logic [3:0] exp, input logic [3:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %b, seen %b", name, exp, got);
        end
    endtask

    // request held until pready is sampled high, released at that same edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk_sys);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        check_word("pslverr", 32'h0, {31'h0, apb_rsp.pslverr}, 32'h1);
        apb_req <= '0;
        if (n >= 50) check_word("pready", 32'h1, 32'h0, 32'h1);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // the expectation is queued first; the monitor pairs it with the answer
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // any 640-cycle window holds exactly ten pulses of a steady divide-by-64
    task automatic count_ticks(input logic [15:0] e);
        logic [15:0] t0;
        idle(100);
        t0 = ticks;
        idle(640);
        check_word("accumulator ticks", {16'h0, e}, {16'h0, ticks - t0}, 32'hffff);
    endtask

    always @(posedge clk_sys) begin
        if (acc_tick === 1'b1) ticks <= ticks + 16'h1;
    end

    always @(posedge clk_sys) begin
        if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1 && !apb_req.pwrite) begin
            if (exp_q.size() == 0) begin
                check_word("unannounced read", 32'h0, 32'hffffffff, 32'hffffffff);
            end else begin
                check_word($sformatf("read %h", apb_req.paddr), exp_q.pop_front(),
                           apb_rsp.prdata, msk_q.pop_front());
            end
        end
    end

    // run length is a few thousand cycles; the ceiling leaves wide margin
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    initial begin
        void'($urandom(32'hc63d));
        idle(16);
        rst_b <= 1'b1;
        idle(4);
        rd(ADDR_SELECT, 32'h0, 32'hff);
        for (int i = 0; i < 4; i++) begin
            v = $urandom & 32'hf0;
            wr(rw_addr[i], v);
            rd(rw_addr[i], v, 32'hff);
        end
        wr(ADDR_CONTROL, 32'h0);
        wr(ADDR_DATA, 32'h0);
        wr(ADDR_ACTION, 32'h0);
        wr(ADDR_SELECT, 32'hf0);
        wr(ADDR_MASK, 32'h60);
        idle(2);
        check_pin("pin enables", 4'b0110, ch_oe);
        wr(ADDR_SELECT, 32'h00);
        idle(2);
        check_pin("pin enables", 4'b0000, ch_oe);
        wr(ADDR_SELECT, 32'hf0);
        wr(ADDR_MASK, 32'h0);
        // ch7 off, ch6 high, ch5 low, ch4 toggle
        wr(ADDR_ACTION, 32'h39);
        wr(ADDR_FORCE, 32'hf0);
        idle(3);
        check_pin("pin data", 4'b0101, ch_out);
        rd(ADDR_FORCE, 32'h0, 32'hffffffff);
        rd(ADDR_FLAGS, 32'h0, 32'h0f);
        wr(ADDR_FORCE, 32'hf0);
        idle(3);
        check_pin("pin data", 4'b0100, ch_out);
        wr(ADDR_MASK, 32'h60);
        wr(ADDR_DATA, 32'h20);
        wr(ADDR_FORCE, 32'hc0);
        idle(3);
        check_pin("pin data", 4'b0010, ch_out);
        rd(ADDR_FLAGS, 32'h0, 32'h0f);
        special_mode <= 1'b1;
        v = $urandom & 32'hffff;
        wr(ADDR_COUNTER, v);
        rd(ADDR_COUNTER, v, 32'hffff);
        special_mode <= 1'b0;
        wr(ADDR_COUNTER, ~v);
        rd(ADDR_COUNTER, v, 32'hffff);
        special_mode <= 1'b1;
        freeze_mode <= 1'b1;
        wr(ADDR_CONTROL, 32'ha0);
        wr(ADDR_COUNTER, 32'habcd);
        idle(20);
        rd(ADDR_COUNTER, 32'habcd, 32'hffff);
        count_ticks(16'd10);
        freeze_mode <= 1'b0;
        wait_mode <= 1'b1;
        wr(ADDR_CONTROL, 32'hc0);
        wr(ADDR_COUNTER, 32'h0bad);
        idle(20);
        rd(ADDR_COUNTER, 32'h0bad, 32'hffff);
        count_ticks(16'd0);
        wait_mode <= 1'b0;
        count_ticks(16'd10);
        wr(ADDR_CONTROL, 32'h0);
        count_ticks(16'd0);
        // counts every clock, so the wrap comes sixteen cycles after the write
        wr(ADDR_CONTROL, 32'h80);
        wr(ADDR_COUNTER, 32'hfff0);
        idle(40);
        wr(ADDR_CONTROL, 32'h0);
        wr(ADDR_COUNTER, 32'h1234);
        special_mode <= 1'b0;
        rd(ADDR_FLAGS, 32'h10, 32'h10);
        rd(ADDR_COUNTER, 32'h1234, 32'hffff);
        rd(ADDR_FLAGS, 32'h10, 32'h10);
        wr(ADDR_CONTROL, 32'h10);
        rd(ADDR_COUNTER, 32'h1234, 32'hffff);
        rd(ADDR_FLAGS, 32'h0, 32'h10);
        wr(ADDR_SELECT, 32'h00);
        // the wrap above matched every compare channel; start from clear flags
        wr(ADDR_FLAGS, 32'h0f);
        wr(ADDR_CONTROL, 32'h90);
        ext_level <= 4'h1;
        idle(10);
        rd(ADDR_FLAGS, 32'h01, 32'h0f);
        rd(ADDR_CHVAL4, 32'h0, 32'h0);
        rd(ADDR_FLAGS, 32'h0, 32'h01);
        rd(12'h0fc, 32'h0, 32'hffffffff);
        idle(4);
        wrap_up();
    end
endmodule // test_timer_capture_compare_ctrl
`default_nettype wire
